// ### logic/mid_pkg.sv
`default_nettype none
package mid_pkg;
  localparam int PC_W = 21;
  localparam int Q_PER_CYC = 4; // oscillator periods per instruction cycle
  localparam logic [1:0] Q_DECODE = 2'd0;
  localparam logic [1:0] Q_PROCESS = 2'd2;
  localparam logic [1:0] Q_WRITE = 2'(Q_PER_CYC - 1);
  // bit operation and relative branch opcodes, word[15:12], then wider prefixes
  localparam logic [3:0] OP_BIT_TOGGLE = 4'h7;
  localparam logic [3:0] OP_BIT_SET = 4'h8;
  localparam logic [3:0] OP_BIT_CLEAR = 4'h9;
  localparam logic [3:0] OP_SKIP_SET = 4'ha;
  localparam logic [3:0] OP_SKIP_CLR = 4'hb;
  localparam logic [3:0] OP_REL = 4'hd;
  localparam logic [4:0] COND_BR_PFX = 5'h1c;
  localparam logic [6:0] CALL_PFX = 7'h76;
  localparam logic [7:0] GOTO_PFX = 8'hef;
  localparam logic [9:0] PTR_LOAD_PFX = 10'h3b8;
  localparam logic [11:0] BANK_LOAD_PFX = 12'h010;
  localparam logic [14:0] IRQ_RET_PFX = 15'h0008;
  localparam logic [14:0] SUB_RET_PFX = 15'h0009;
  localparam logic [12:0] TABLE_PFX = 13'h0001;
  // literal operation codes, word[11:8] under prefix 0000
  localparam logic [3:0] LIT_SUB = 4'h8;
  localparam logic [3:0] LIT_OR = 4'h9;
  localparam logic [3:0] LIT_XOR = 4'ha;
  localparam logic [3:0] LIT_AND = 4'hb;
  localparam logic [3:0] LIT_RET = 4'hc;
  localparam logic [3:0] LIT_MUL = 4'hd;
  localparam logic [3:0] LIT_LOAD = 4'he;
  localparam logic [3:0] LIT_ADD = 4'hf;
  // whole control words
  localparam logic [15:0] W_SLEEP = 16'h0003;
  localparam logic [15:0] W_WDT_CLR = 16'h0004;
  localparam logic [15:0] W_PUSH = 16'h0005;
  localparam logic [15:0] W_POP = 16'h0006;
  localparam logic [15:0] W_DAW = 16'h0007;
  localparam logic [15:0] W_RESET = 16'h00ff;
  // addressing
  localparam logic [7:0] EXT_LIMIT = 8'h5f;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  // wishbone register byte offsets
  localparam logic [7:0] RA_CTRL = 8'h00;
  localparam logic [7:0] RA_STAT = 8'h04;
  localparam logic [7:0] RA_WORK = 8'h08;
  localparam logic [7:0] RA_PC = 8'h0c;
  localparam logic [7:0] RA_PROD = 8'h10;
  localparam logic [7:0] RA_TBL = 8'h14;
  localparam logic [1:0] CTRL_RST = 2'h0; // bit0 extended set, bit1 prescaler on timer zero
  localparam logic PWR_FLAG_RST = 1'b1; // time-out and power-down after reset
  typedef struct packed {logic n; logic ov; logic z; logic dc; logic c;} mid_flags_s;
  typedef enum logic [1:0] {ST_EXEC = 2'b00, ST_WORD2 = 2'b01, ST_FLUSH = 2'b11} mid_state_e;
endpackage
`default_nettype wire

// ### logic/mid_core.sv
// Behaviour
// [RULE1] port rewrite takes pin levels, not latch
// [RULE2] timer-zero write clears assigned prescaler
// [RULE3] pc change or true test adds nop cycle
// [RULE4] 1111 word alone is nop, else operand
// [RULE5] bit clear/set/toggle/skip encodings and timing
// [RULE6] conditional branches on four flags, 1 or 2
// [RULE7] relative branch and call, 11-bit offset
// [RULE8] two-word call, s saves shadow registers
// [RULE9] two-word absolute jump, 20-bit target
// [RULE10] watchdog clear, standby set power flags; adjust
// [RULE11] stack push/pop one cycle, flags kept
// [RULE12] word 00ff performs full software reset
// [RULE13] interrupt return re-enables both irq enables
// [RULE14] subroutine return two cycles, optional shadow restore
// [RULE15] literal return loads working register, returns
// [RULE16] literal alu ops and their flag effects
// [RULE17] two-word pointer load of 12 bits
// [RULE18] bank load writes low four bank bits
// [RULE19] table reads two cycles, four pointer modes
// [RULE20] table writes two cycles, four pointer modes
// [RULE21] extended set: f<=95 uses indexed offset
// [RULE22] access bit picks access bank or bank
// [RULE23] destination bit picks working or file; no op here decodes it, bit ops always write the file
// [RULE24] branch target is pc+2+2n
// [RULE25] one instruction cycle is four clocks
`default_nettype none
module mid_core
  import mid_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // program memory fetch
  output logic [PC_W-1:0] pm_addr,
  input wire logic [15:0] pm_data,
  // file register bus
  output logic [11:0] fr_addr,
  input wire logic [7:0] fr_rdata,
  input wire logic fr_is_port,
  input wire logic [7:0] pin_in,
  input wire logic fr_is_timer_zero,
  output logic fr_wr,
  output logic [7:0] fr_wdata,
  output logic tmr_psc_clr,
  // return stack
  input wire logic [PC_W-1:0] stk_top,
  output logic stk_push,
  output logic stk_pop,
  output logic [PC_W-1:0] stk_data,
  // table access and pointer load
  output logic tbl_rd,
  output logic tbl_wr,
  output logic [PC_W-1:0] tbl_addr,
  output logic ptr_wr,
  output logic [1:0] ptr_sel,
  output logic [11:0] ptr_val,
  // power and interrupt control
  output logic wdt_clr,
  output logic sleep_req,
  output logic soft_rst,
  output logic irq_hi_en,
  output logic irq_lo_en
);

  // branch condition: index 0..3 = zero, carry, overflow, negative; odd = inverted
  function automatic logic cond_ok(input mid_flags_s f, input logic [2:0] cc);
    logic v;
    v = 1'b0;
    unique case (cc[2:1])
      2'd0: v = f.z;
      2'd1: v = f.c;
      2'd2: v = f.ov;
      2'd3: v = f.n;
    endcase
    return v ^ cc[0];
  endfunction

  // file address from a bit-op word
  function automatic logic [11:0] file_addr(input logic [15:0] w, input logic ext,
                                            input logic [3:0] bank, input logic [11:0] base);
    logic [11:0] a;
    a = {bank, w[7:0]};
    if (!w[8] && ext && w[7:0] <= EXT_LIMIT) begin
      a = base + {4'h0, w[7:0]}; // RULE21
    end else if (!w[8]) begin
      a = (w[7:0] < ACC_SPLIT) ? {4'h0, w[7:0]} : {4'hf, w[7:0]}; // RULE22
    end
    return a;
  endfunction

  logic [1:0] q_ff;
  mid_state_e st_ff;
  logic [PC_W-1:0] pc_ff;
  logic [15:0] ir_ff;
  logic [15:0] op1_ff;
  logic [7:0] work_ff;
  logic [7:0] sh_work_ff;
  mid_flags_s flg_ff;
  mid_flags_s sh_flg_ff;
  logic [3:0] bank_sel_ff;
  logic [3:0] sh_bank_ff;
  logic [15:0] prod_ff;
  logic [PC_W-1:0] table_pointer_ff;
  logic [11:0] idx_base_ff;
  logic [1:0] ctrl_ff;
  logic time_out_ff, pwr_down_ff, irq_hi_ff, irq_lo_ff;
  logic fr_wr_ff, psc_clr_ff, push_ff, pop_ff, tbl_rd_ff, tbl_wr_ff, ptr_wr_ff;
  logic wdt_clr_ff, sleep_ff, soft_rst_ff, ack_ff;
  logic [11:0] fr_addr_ff;
  logic [7:0] fr_wdata_ff;
  logic [PC_W-1:0] stk_data_ff;
  logic [PC_W-1:0] tbl_addr_ff;
  logic [1:0] ptr_sel_ff;
  logic [11:0] ptr_val_ff;
  logic [31:0] rdata_ff;

  // decode of the word in hand
  logic cyc_end, exe, sw_rst, clr;
  logic [3:0] hi4, lop, lit4;
  logic [7:0] k, src, bmask, bit_res;
  logic is_bitwr, skip, take_br, is_rel, is_call1, is_goto1, is_ptr1, two_word;
  logic is_lit, is_ret, is_interrupt_return_op, is_tbl, is_bank_load_op, is_wdtclr, is_sleep, is_pushpop;
  logic jmp2, call2, ptr2;
  logic [PC_W-1:0] br_tgt, far_tgt;

  assign cyc_end = (q_ff == Q_WRITE);
  assign exe = (st_ff == ST_EXEC);
  assign hi4 = ir_ff[15:12];
  assign lop = ir_ff[11:8];
  assign lit4 = ir_ff[3:0];
  assign k = ir_ff[7:0];
  assign src = fr_is_port ? pin_in : fr_rdata; // RULE1
  assign bmask = 8'h01 << ir_ff[11:9];
  assign is_bitwr = exe && (hi4 == OP_BIT_TOGGLE || hi4 == OP_BIT_SET || hi4 == OP_BIT_CLEAR);
  assign skip = exe && ((hi4 == OP_SKIP_CLR && !(|(src & bmask))) ||
                        (hi4 == OP_SKIP_SET && (|(src & bmask)))); // RULE5
  assign take_br = exe && ir_ff[15:11] == COND_BR_PFX && cond_ok(flg_ff, ir_ff[10:8]); // RULE6
  assign is_rel = exe && hi4 == OP_REL; // RULE7
  assign is_call1 = exe && ir_ff[15:9] == CALL_PFX;
  assign is_goto1 = exe && ir_ff[15:8] == GOTO_PFX;
  assign is_ptr1 = exe && ir_ff[15:6] == PTR_LOAD_PFX;
  assign two_word = is_call1 || is_goto1 || is_ptr1;
  assign is_lit = exe && hi4 == 4'h0 && ir_ff[11];
  assign is_interrupt_return_op = exe && ir_ff[15:1] == IRQ_RET_PFX;
  assign is_ret = is_interrupt_return_op || (exe && ir_ff[15:1] == SUB_RET_PFX) || (is_lit && lop == LIT_RET);
  assign is_tbl = exe && ir_ff[15:3] == TABLE_PFX;
  assign is_bank_load_op = exe && ir_ff[15:4] == BANK_LOAD_PFX;
  assign is_wdtclr = exe && ir_ff == W_WDT_CLR;
  assign is_sleep = exe && ir_ff == W_SLEEP;
  assign is_pushpop = exe && (ir_ff == W_PUSH || ir_ff == W_POP);
  assign sw_rst = cyc_end && exe && ir_ff == W_RESET; // RULE12
  assign clr = rst || sw_rst;
  // second word: only what the first word asked for uses it
  assign jmp2 = st_ff == ST_WORD2 && op1_ff[11:8] != 4'he;
  assign call2 = jmp2 && op1_ff[11:9] == 3'b110;
  assign ptr2 = st_ff == ST_WORD2 && op1_ff[11:8] == 4'he;
  assign far_tgt = {ir_ff[11:0], op1_ff[7:0], 1'b0}; // RULE4 RULE9
  // relative target from incremented pc
  assign br_tgt = hi4 == OP_REL ? pc_ff + 21'd2 + {{9{ir_ff[10]}}, ir_ff[10:0], 1'b0}
                                : pc_ff + 21'd2 + {{12{k[7]}}, k, 1'b0}; // RULE24

  // bit op result
  always_comb begin
    unique case (hi4)
      OP_BIT_CLEAR: bit_res = src & ~bmask;
      OP_BIT_SET: bit_res = src | bmask;
      default: bit_res = src ^ bmask;
    endcase
  end

  // q phase counter; execution commits in the last phase
  always_ff @(posedge clk) begin
    if (clr) begin
      q_ff <= Q_DECODE;
    end else begin
      q_ff <= q_ff + 2'd1; // RULE25
    end
  end

  // sequencing and program counter
  always_ff @(posedge clk) begin
    if (clr) begin
      st_ff <= ST_EXEC;
      pc_ff <= '0;
      op1_ff <= '0;
    end else if (cyc_end) begin
      unique case (st_ff)
        ST_EXEC: begin
          pc_ff <= pc_ff + 21'd2;
          st_ff <= ST_EXEC;
          if (two_word) begin
            st_ff <= ST_WORD2; // RULE8 RULE9 RULE17
            op1_ff <= ir_ff;
          end else if (take_br || is_rel) begin
            pc_ff <= br_tgt; // RULE3 RULE7
            st_ff <= ST_FLUSH;
          end else if (skip) begin
            pc_ff <= pc_ff + 21'd4; // RULE5
            st_ff <= ST_FLUSH;
          end else if (is_ret) begin
            pc_ff <= stk_top; // RULE13 RULE14 RULE15
            st_ff <= ST_FLUSH;
          end else if (is_tbl) begin
            st_ff <= ST_FLUSH; // RULE19 RULE20
          end
        end
        ST_WORD2: begin
          pc_ff <= jmp2 ? far_tgt : pc_ff + 21'd2;
          st_ff <= ST_EXEC;
        end
        ST_FLUSH: st_ff <= ST_EXEC; // RULE3
        default: st_ff <= ST_EXEC;
      endcase
    end
  end

  // fetch latch and file address in the decode phase
  always_ff @(posedge clk) begin
    if (clr) begin
      ir_ff <= '0;
      fr_addr_ff <= '0;
    end else if (q_ff == Q_DECODE) begin
      ir_ff <= pm_data;
      fr_addr_ff <= file_addr(pm_data, ctrl_ff[0], bank_sel_ff, idx_base_ff);
    end
  end

  // bit op write-back, always into the file register
  always_ff @(posedge clk) begin
    if (clr) begin
      fr_wr_ff <= 1'b0;
      fr_wdata_ff <= '0;
      psc_clr_ff <= 1'b0;
    end else begin
      fr_wr_ff <= q_ff == Q_PROCESS && is_bitwr; // RULE23
      psc_clr_ff <= q_ff == Q_PROCESS && is_bitwr && fr_is_timer_zero && ctrl_ff[1]; // RULE2
      if (q_ff == Q_PROCESS) begin
        fr_wdata_ff <= bit_res;
      end
    end
  end

  // working register, flags, product and shadow copies
  logic [8:0] sum9, sub9, dsum;
  logic [4:0] hsum, hsub;
  logic [7:0] adj;
  always_comb begin
    sum9 = {1'b0, work_ff} + {1'b0, k};
    sub9 = {1'b0, k} + {1'b0, ~work_ff} + 9'd1;
    hsum = {1'b0, work_ff[3:0]} + {1'b0, k[3:0]};
    hsub = {1'b0, k[3:0]} + {1'b0, ~work_ff[3:0]} + 5'd1;
    adj = 8'h00;
    if (work_ff[3:0] > 4'h9 || flg_ff.dc) adj = 8'h06;
    if (work_ff[7:4] > 4'h9 || flg_ff.c || (work_ff[7:4] == 4'h9 && work_ff[3:0] > 4'h9)) begin
      adj = adj | 8'h60;
    end
    dsum = {1'b0, work_ff} + {1'b0, adj};
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      work_ff <= '0;
      flg_ff <= '0;
      prod_ff <= '0;
      sh_work_ff <= '0;
      sh_flg_ff <= '0;
      sh_bank_ff <= '0;
      bank_sel_ff <= '0;
    end else if (cyc_end) begin
      if (is_lit) begin
        unique case (lop)
          LIT_ADD: begin
            work_ff <= sum9[7:0]; // RULE16
            flg_ff <= '{n: sum9[7], ov: work_ff[7] == k[7] && sum9[7] != k[7],
                        z: sum9[7:0] == 8'h00, dc: hsum[4], c: sum9[8]};
          end
          LIT_SUB: begin
            work_ff <= sub9[7:0];
            flg_ff <= '{n: sub9[7], ov: work_ff[7] != k[7] && sub9[7] != k[7],
                        z: sub9[7:0] == 8'h00, dc: hsub[4], c: sub9[8]};
          end
          LIT_AND, LIT_OR, LIT_XOR: begin
            work_ff <= lop == LIT_AND ? work_ff & k : lop == LIT_OR ? work_ff | k : work_ff ^ k;
            flg_ff.z <= (lop == LIT_AND ? work_ff & k : lop == LIT_OR ? work_ff | k
                         : work_ff ^ k) == 8'h00;
            flg_ff.n <= lop == LIT_AND ? work_ff[7] & k[7] : lop == LIT_OR ? work_ff[7] | k[7]
                        : work_ff[7] ^ k[7];
          end
          LIT_MUL: prod_ff <= work_ff * k;
          LIT_LOAD, LIT_RET: work_ff <= k; // RULE15
          default: work_ff <= work_ff;
        endcase
      end
      if (exe && ir_ff == W_DAW) begin
        work_ff <= dsum[7:0]; // RULE10
        flg_ff.c <= flg_ff.c | dsum[8] | adj[5];
      end
      if (is_bank_load_op) begin
        bank_sel_ff <= lit4; // RULE18
      end
      if ((is_interrupt_return_op || (exe && ir_ff[15:1] == SUB_RET_PFX)) && ir_ff[0]) begin
        work_ff <= sh_work_ff; // RULE13 RULE14
        flg_ff <= sh_flg_ff;
        bank_sel_ff <= sh_bank_ff;
      end
      if (call2 && op1_ff[8]) begin
        sh_work_ff <= work_ff; // RULE8
        sh_flg_ff <= flg_ff;
        sh_bank_ff <= bank_sel_ff;
      end
    end
  end

  // stack, table, pointer and power side effects, one-cycle pulses
  always_ff @(posedge clk) begin
    if (clr) begin
      push_ff <= 1'b0;
      pop_ff <= 1'b0;
      stk_data_ff <= '0;
      tbl_rd_ff <= 1'b0;
      tbl_wr_ff <= 1'b0;
      tbl_addr_ff <= '0;
      table_pointer_ff <= '0;
      ptr_wr_ff <= 1'b0;
      ptr_sel_ff <= '0;
      ptr_val_ff <= '0;
      idx_base_ff <= '0;
      wdt_clr_ff <= 1'b0;
      sleep_ff <= 1'b0;
      time_out_ff <= PWR_FLAG_RST;
      pwr_down_ff <= PWR_FLAG_RST;
      irq_hi_ff <= 1'b0;
      irq_lo_ff <= 1'b0;
    end else begin
      push_ff <= cyc_end && ((is_rel && ir_ff[11]) || call2 || (exe && ir_ff == W_PUSH)); // RULE11
      pop_ff <= cyc_end && (is_ret || (exe && ir_ff == W_POP));
      tbl_rd_ff <= cyc_end && is_tbl && !ir_ff[2]; // RULE19
      tbl_wr_ff <= cyc_end && is_tbl && ir_ff[2]; // RULE20
      ptr_wr_ff <= cyc_end && ptr2; // RULE17
      wdt_clr_ff <= cyc_end && is_wdtclr;
      sleep_ff <= cyc_end && is_sleep;
      if (cyc_end) begin
        stk_data_ff <= pc_ff + 21'd2;
        if (is_tbl) begin
          tbl_addr_ff <= ir_ff[1:0] == 2'd3 ? table_pointer_ff + 21'd1 : table_pointer_ff;
          if (ir_ff[1:0] == 2'd2) begin
            table_pointer_ff <= table_pointer_ff - 21'd1;
          end else if (ir_ff[1:0] != 2'd0) begin
            table_pointer_ff <= table_pointer_ff + 21'd1;
          end
        end
        if (ptr2) begin
          ptr_sel_ff <= op1_ff[5:4];
          ptr_val_ff <= {op1_ff[3:0], ir_ff[7:0]};
          if (op1_ff[5:4] == 2'd2) begin
            idx_base_ff <= {op1_ff[3:0], ir_ff[7:0]};
          end
        end
        if (is_wdtclr || is_sleep) begin
          time_out_ff <= 1'b1; // RULE10
          pwr_down_ff <= is_wdtclr;
        end
        if (is_interrupt_return_op) begin
          irq_hi_ff <= 1'b1; // RULE13
          irq_lo_ff <= 1'b1;
        end
      end
    end
  end

  // software reset pulse survives its own clear
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= sw_rst; // RULE12
    end
  end

  // wishbone slave: one wait state, ack for every address, unmapped reads zero
  always_ff @(posedge clk) begin
    if (clr) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
      ctrl_ff <= CTRL_RST;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
      if (wb_cyc_i && wb_stb_i && !ack_ff) begin
        if (wb_we_i && wb_adr_i == RA_CTRL && wb_sel_i[0]) begin
          ctrl_ff <= wb_dat_i[1:0];
        end
        unique case (wb_adr_i)
          RA_CTRL: rdata_ff <= {30'h0, ctrl_ff};
          RA_STAT: rdata_ff <= {23'h0, irq_lo_ff, irq_hi_ff, pwr_down_ff, time_out_ff, flg_ff};
          RA_WORK: rdata_ff <= {20'h0, bank_sel_ff, work_ff};
          RA_PC: rdata_ff <= {11'h0, pc_ff};
          RA_PROD: rdata_ff <= {16'h0, prod_ff};
          RA_TBL: rdata_ff <= {11'h0, table_pointer_ff};
          default: rdata_ff <= 32'h0;
        endcase
      end
    end
  end

  assign wb_dat_o = rdata_ff;
  assign wb_ack_o = ack_ff;
  assign pm_addr = pc_ff;
  assign fr_addr = fr_addr_ff;
  assign fr_wr = fr_wr_ff;
  assign fr_wdata = fr_wdata_ff;
  assign tmr_psc_clr = psc_clr_ff;
  assign stk_push = push_ff;
  assign stk_pop = pop_ff;
  assign stk_data = stk_data_ff;
  assign tbl_rd = tbl_rd_ff;
  assign tbl_wr = tbl_wr_ff;
  assign tbl_addr = tbl_addr_ff;
  assign ptr_wr = ptr_wr_ff;
  assign ptr_sel = ptr_sel_ff;
  assign ptr_val = ptr_val_ff;
  assign wdt_clr = wdt_clr_ff;
  assign sleep_req = sleep_ff;
  assign soft_rst = soft_rst_ff;
  assign irq_hi_en = irq_hi_ff;
  assign irq_lo_en = irq_lo_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_q_period: assert property (cyc_end |=> !cyc_end [*3] ##1 cyc_end) // RULE25
    else $error("instruction cycle is not four clocks");
  chk_port_source: assert property ((q_ff == Q_PROCESS && is_bitwr && fr_is_port) // RULE1
    |=> ((fr_wdata_ff ^ $past(pin_in)) & ~bmask) == 8'h00)
    else $error("port rewrite did not use pin levels");
  chk_psc_clear: assert property (psc_clr_ff |-> fr_wr_ff && ctrl_ff[1]) // RULE2
    else $error("prescaler cleared without timer write");
  chk_flush_quiet: assert property (st_ff == ST_FLUSH |-> !fr_wr_ff) // RULE3
    else $error("extra cycle is not a nop");
  chk_skip_two: assert property ((cyc_end && skip && !sw_rst) // RULE5
    |=> st_ff == ST_FLUSH ##4 st_ff == ST_EXEC)
    else $error("skip did not add one cycle");
  chk_branch_tgt: assert property (cyc_end && (take_br || is_rel) |=> pc_ff == $past(br_tgt)) // RULE24
    else $error("branch target wrong");
  chk_far_jump: assert property ((cyc_end && jmp2) // RULE9
    |=> pc_ff == $past(far_tgt) && st_ff == ST_EXEC)
    else $error("two-word jump target wrong");
  chk_watchdog_clear_op_flags: assert property (cyc_end && is_wdtclr // RULE10
    |=> time_out_ff && pwr_down_ff && wdt_clr_ff)
    else $error("watchdog clear flags wrong");
  chk_bank_load: assert property (cyc_end && is_bank_load_op |=> bank_sel_ff == $past(lit4)) // RULE18
    else $error("bank load wrong");
  chk_stack_flags: assert property (cyc_end && is_pushpop // RULE11
    |=> flg_ff == $past(flg_ff) && (push_ff || pop_ff) && st_ff == ST_EXEC)
    else $error("stack op changed flags or timing");
  chk_irq_reenable: assert property (cyc_end && is_interrupt_return_op // RULE13
    |=> irq_hi_ff && irq_lo_ff && pop_ff && st_ff == ST_FLUSH)
    else $error("interrupt return wrong");
endmodule
`default_nettype wire

// ### tb/mid_mem.sv
`default_nettype none
module mid_mem
  import mid_pkg::*;
(
  // fetch side
  input wire logic [PC_W-1:0] pm_addr,
  output logic [15:0] pm_data,
  // file register side
  input wire logic [11:0] fr_addr,
  output logic [7:0] fr_rdata,
  output logic fr_is_port,
  output logic fr_is_timer_zero,
  output logic [7:0] pin_in,
  output logic [PC_W-1:0] stk_top
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rom [0:31];
  // small program, unused words hold the reset word so a runaway shows up
  initial begin
    foreach (rom[i]) rom[i] = 16'h00ff;
    rom[0] = 16'h0e05; // load 5
    rom[1] = 16'h0f03; // add 3
    rom[2] = 16'h8700; // set bit 3 of the port
    rom[3] = 16'h9101; // clear bit 0 of timer zero
    rom[4] = 16'hd001; // relative branch over one word
    rom[6] = 16'hf123; // lone operand word
    rom[7] = 16'hef0b; // absolute jump to 0x16
    rom[8] = 16'hf000;
    rom[11] = 16'h0003; // standby
    rom[12] = 16'h0004; // watchdog clear
    rom[13] = 16'h0010; // interrupt return
    rom[14] = 16'hee1a; // pointer 1 load 0xabc
    rom[15] = 16'hf0bc;
    rom[16] = 16'h0009; // table read, post-increment
    rom[17] = 16'he002; // branch on zero, not taken
    rom[18] = 16'h0005; // push
    rom[19] = 16'h0103; // bank load 3
    rom[20] = 16'hb100; // pins read low, so skip the reset word below
    rom[22] = 16'hd7ff; // park in a tight loop
  end
  // memory answers at once; latch of the port reads high, pins are held low
  assign pm_data = rom[pm_addr[5:1]];
  assign fr_is_port = (fr_addr[7:0] == 8'h00);
  assign fr_is_timer_zero = (fr_addr[7:0] == 8'h01);
  assign fr_rdata = 8'hff;
  assign pin_in = 8'h00;
  assign stk_top = 21'h00001c; // return lands on the pointer load
endmodule
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
module testbench
  import mid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [PC_W-1:0] psh_data, tbl_seen;
  int n_pop;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [PC_W-1:0] pm_addr, stk_top, stk_data, tbl_addr;
  logic [15:0] pm_data;
  logic [11:0] fr_addr, ptr_val;
  logic [7:0] fr_rdata, pin_in, fr_wdata, port_wd, tmr_wd;
  logic fr_is_port, fr_is_timer_zero, fr_wr, tmr_psc_clr, port_psc, tmr_psc;
  logic stk_push, stk_pop, tbl_rd, tbl_wr, ptr_wr, wdt_clr, sleep_req, soft_rst;
  logic irq_hi_en, irq_lo_en;
  logic [1:0] ptr_sel, ptr_sel_seen;
  logic [11:0] ptr_val_seen;
  int miscompares, samples_checked, cyc_n, t_tmr, t_slp, t_wdt, t_ptr, t_tbl, t_psh, n_rst;
  mid_core dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .pm_addr(pm_addr), .pm_data(pm_data), .fr_addr(fr_addr),
    .fr_rdata(fr_rdata), .fr_is_port(fr_is_port), .pin_in(pin_in),
    .fr_is_timer_zero(fr_is_timer_zero), .fr_wr(fr_wr), .fr_wdata(fr_wdata),
    .tmr_psc_clr(tmr_psc_clr), .stk_top(stk_top), .stk_push(stk_push), .stk_pop(stk_pop),
    .stk_data(stk_data), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr),
    .ptr_wr(ptr_wr), .ptr_sel(ptr_sel), .ptr_val(ptr_val), .wdt_clr(wdt_clr),
    .sleep_req(sleep_req), .soft_rst(soft_rst), .irq_hi_en(irq_hi_en), .irq_lo_en(irq_lo_en));
  mid_mem mem (.pm_addr(pm_addr), .pm_data(pm_data), .fr_addr(fr_addr), .fr_rdata(fr_rdata),
    .fr_is_port(fr_is_port), .fr_is_timer_zero(fr_is_timer_zero), .pin_in(pin_in),
    .stk_top(stk_top));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // event monitor: clock stamps of pulses and captured write data
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (fr_wr === 1'b1 && fr_is_port === 1'b1) begin
      port_wd <= fr_wdata;
      port_psc <= tmr_psc_clr;
    end
    if (fr_wr === 1'b1 && fr_is_timer_zero === 1'b1) begin
      tmr_wd <= fr_wdata;
      tmr_psc <= tmr_psc_clr;
      t_tmr <= cyc_n;
    end
    if (sleep_req === 1'b1) t_slp <= cyc_n;
    if (wdt_clr === 1'b1) t_wdt <= cyc_n;
    if (tbl_rd === 1'b1) begin
      t_tbl <= cyc_n;
      tbl_seen <= tbl_addr;
    end
    if (stk_push === 1'b1) begin
      t_psh <= cyc_n;
      psh_data <= stk_data;
    end
    if (stk_pop === 1'b1) n_pop <= n_pop + 1;
    if (soft_rst === 1'b1) n_rst <= n_rst + 1;
    if (ptr_wr === 1'b1) begin
      t_ptr <= cyc_n;
      ptr_sel_seen <= ptr_sel;
      ptr_val_seen <= ptr_val;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hf;
    wb_adr <= a;
    wb_wdat <= d;
    do @(posedge clk); while (wb_ack !== 1'b1);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // registers after reset, control write, unmapped place
  task automatic test_regs();
    wb(RA_STAT, 1'b0, 32'h0, q);
    check(q & 32'h1ff, 32'h060);
    wb(RA_CTRL, 1'b1, 32'h2, q);
    wb(RA_CTRL, 1'b0, 32'h0, q);
    check(q & 32'h3, 32'h2);
    wb(8'h3c, 1'b1, 32'hffff_ffff, q);
    wb(8'h3c, 1'b0, 32'h0, q);
    check(q, 32'h0);
  endtask
  // run the program and judge side effects and spacing of events
  task automatic test_program();
    repeat (120) @(posedge clk);
    check(port_wd, 8'h08);
    check(port_psc, 1'b0);
    check(tmr_wd, 8'hfe);
    check(tmr_psc, 1'b1);
    check(t_slp - t_tmr, 25);
    check(t_wdt - t_slp, 4);
    check(t_ptr - t_wdt, 16);
    check({ptr_sel_seen, ptr_val_seen}, {2'd1, 12'habc});
    check(t_tbl - t_ptr, 4);
    check(t_psh - t_tbl, 12);
    check(tbl_seen, 21'h000000);
    check(psh_data, 21'h000026);
    check(n_pop, 1);
    check(n_rst, 0);
    check({irq_hi_en, irq_lo_en}, 2'b11);
    wb(RA_STAT, 1'b0, 32'h0, q);
    check(q & 32'h1ff, 32'h1e0);
    wb(RA_WORK, 1'b0, 32'h0, q);
    check(q & 32'hfff, 32'h308);
    wb(RA_TBL, 1'b0, 32'h0, q);
    check(q, 32'h1);
    wb(RA_PC, 1'b0, 32'h0, q);
    check(q, 32'h2c);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_wdat} = '0;
    {miscompares, samples_checked, cyc_n, n_rst, n_pop} = '0;
    {t_tmr, t_slp, t_wdt, t_ptr, t_tbl, t_psh} = '0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    test_program();
    results();
  end
  // hang guard, well beyond the roughly 160 clocks the tests need
  initial begin
    #20us;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
